// [shared/sac_pkg.sv]
/*
 Shared constants and types of the converter control block.
 Assumes a single 20 MHz clock and a synchronous active-low reset.
*/
// Contract
// - Act only with enable high, select low.
// - Byte address low starts twelve-bit conversion.
// - Byte address high starts eight-bit conversion.
// - Byte reads enable upper or lower buffers.
// - Word format high drives all twelve lines.
// - Low byte carries four bits, then zeros.
// - Busy flag high throughout each conversion.
// - Full control and standalone arrangements both work.
// - Start enables clock, clears approximation register.
// - Starts ignored and reads blocked while converting.
// - Bits tried MSB first, kept when below.
// - Falling read/convert edge starts standalone conversion.
`default_nettype none
package sac_pkg;
    localparam int unsigned RES_BITS = 12;
    localparam int unsigned SHORT_BITS = 8;
    localparam logic [3:0] LAST_FULL = 4'h0;
    localparam logic [3:0] LAST_SHORT = 4'h4;
    localparam logic [3:0] FIRST_BIT = 4'hb;
    localparam logic [11:0] RESULT_RESET = 12'h000;
    localparam logic [3:0] TRAIL_ZEROS = 4'h0;
    typedef enum logic [0:0] {
        SAC_IDLE = 1'b0,
        SAC_CONV = 1'b1
    } sac_state_type;
endpackage : sac_pkg
`default_nettype wire

// [logic/sac_sar.sv]
/*
 Successive approximation register stepping one bit per enabled clock.
 Assumes the comparator answer is synchronous to the clock.
*/
`default_nettype none
module sac_sar (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    // Control.
    input wire logic start,
    input wire logic short_mode,
    input wire logic comp_below,
    // Results.
    output logic busy,
    output logic [11:0] trial,
    output logic [11:0] result
);
    sac_pkg::sac_state_type state_r;
    logic [3:0] bit_r;
    logic [11:0] sar_r;
    logic short_r;
    logic last;

    assign last = (bit_r == (short_r ? sac_pkg::LAST_SHORT : sac_pkg::LAST_FULL));
    assign busy = (state_r == sac_pkg::SAC_CONV);
    // Trial code adds the bit under test to the bits already kept.
    assign trial = sar_r | (busy ? (12'h001 << bit_r) : 12'h000);

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state_r <= sac_pkg::SAC_IDLE;
            bit_r <= sac_pkg::FIRST_BIT;
            sar_r <= sac_pkg::RESULT_RESET;
            short_r <= 1'b0;
            result <= sac_pkg::RESULT_RESET;
        end else if (clk_en) begin
            unique case (state_r)
                sac_pkg::SAC_IDLE: begin
                    if (start) begin
                        sar_r <= sac_pkg::RESULT_RESET;
                        bit_r <= sac_pkg::FIRST_BIT;
                        short_r <= short_mode;
                        state_r <= sac_pkg::SAC_CONV;
                    end
                end
                sac_pkg::SAC_CONV: begin
                    sar_r[bit_r] <= comp_below;
                    bit_r <= bit_r - 4'h1;
                    if (last) begin
                        // The bit under test is still clear in sar_r, so one OR completes it.
                        result <= sar_r | (comp_below ? (12'h001 << bit_r) : 12'h000);
                        state_r <= sac_pkg::SAC_IDLE;
                    end
                end
            endcase
        end
    end
endmodule : sac_sar
`default_nettype wire

// [logic/sac_control.sv]
/*
 Control logic of a successive approximation converter: decode, busy flag, output buffers.
 Assumes pins synchronous to the clock and an external comparator answer.
*/
`default_nettype none
module sac_control (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    // Bus control pins.
    input wire logic chip_enable,
    input wire logic chip_select_b,
    input wire logic read_convert,
    input wire logic byte_address_bit,
    input wire logic word_format,
    // Analog side.
    input wire logic comp_below,
    output logic [11:0] dac_code,
    output logic conv_clock_en,
    // Status and data.
    output logic conversion_busy_flag,
    output logic [11:0] result_data_lines,
    output logic [11:0] result_data_oe
);
    logic selected;
    logic start;
    logic rd_prev_r;
    logic selected_prev_r;
    logic busy;
    logic reading;
    logic [11:0] result;

    assign selected = chip_enable && !chip_select_b;
    assign start = selected && !read_convert && (rd_prev_r || !selected_prev_r);

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rd_prev_r <= 1'b1;
            selected_prev_r <= 1'b0;
        end else if (clk_en) begin
            rd_prev_r <= read_convert;
            selected_prev_r <= selected;
        end
    end

    // Twelve or eight bits by byte address.
    // Short cycle when byte address high.
    sac_sar u_sar (
        .clock(clock),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .start(start),
        .short_mode(byte_address_bit),
        .comp_below(comp_below),
        .busy(busy),
        .trial(dac_code),
        .result(result)
    );

    assign conversion_busy_flag = busy;
    assign conv_clock_en = busy;
    assign reading = selected && read_convert && !busy;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            result_data_lines <= sac_pkg::RESULT_RESET;
        end else if (clk_en) begin
            if (word_format || !byte_address_bit) begin
                result_data_lines <= result;
            end else begin
                // Low nibble in upper half, zeros below.
                result_data_lines <= {4'h0, result[3:0], sac_pkg::TRAIL_ZEROS};
            end
        end
    end

    always_comb begin
        result_data_oe = 12'h000;
        if (reading) begin
            if (word_format) begin
                result_data_oe = 12'hfff;
            end else if (!byte_address_bit) begin
                result_data_oe = 12'hff0;
            end else begin
                result_data_oe = 12'h0ff;
            end
        end
    end

    // Assertions.
    a_float_idle: assert property (@(posedge clock) disable iff (!rst_b)
        !reading |-> result_data_oe == 12'h000) else $error("Data lines driven without read.");
    a_busy_blocks_read: assert property (@(posedge clock) disable iff (!rst_b)
        busy |-> result_data_oe == 12'h000) else $error("Read during conversion.");
    a_start_raises_busy: assert property (@(posedge clock) disable iff (!rst_b)
        (clk_en && start && !busy) |=> conversion_busy_flag) else $error("Busy did not rise.");
    a_word_all_lines: assert property (@(posedge clock) disable iff (!rst_b)
        (reading && word_format) |-> result_data_oe == 12'hfff) else $error("Word not enabled.");
    a_byte_select: assert property (@(posedge clock) disable iff (!rst_b)
        (reading && !word_format && byte_address_bit) |-> result_data_oe == 12'h0ff)
        else $error("Low byte enable wrong.");
    a_short_length: assert property (@(posedge clock) disable iff (!rst_b)
        s_start_short ##1 clk_en[*8] |=> !busy)
        else $error("Short conversion length wrong.");
    a_full_length: assert property (@(posedge clock) disable iff (!rst_b)
        s_start_full ##1 s_run_eight
        |=> busy) else $error("Full conversion ended early.");
    a_clock_gate: assert property (@(posedge clock) disable iff (!rst_b)
        conv_clock_en == conversion_busy_flag) else $error("Clock gate mismatch.");
    a_decode_none: assert property (@(posedge clock) disable iff (!rst_b)
        !selected |-> !reading) else $error("Read without select.");

    // Helper logic for the assertions.
    // The run length is counted here because a twelve-cycle repetition is too long to unroll.
    logic start_taken;
    logic [3:0] run_len_r;
    logic short_run_r;

    assign start_taken = clk_en && start && !busy;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            run_len_r <= 4'h0;
            short_run_r <= 1'b0;
        end else if (clk_en) begin
            if (start_taken) begin
                run_len_r <= 4'h0;
                short_run_r <= byte_address_bit;
            end else if (busy) begin
                run_len_r <= run_len_r + 4'h1;
            end
        end
    end

    sequence s_start_full;
        start_taken && !byte_address_bit;
    endsequence

    sequence s_start_short;
        start_taken && byte_address_bit;
    endsequence

    sequence s_run_eight;
        (clk_en && busy)[*8];
    endsequence

    sequence s_busy_end;
        $fell(busy);
    endsequence

    a_full_count: assert property (@(posedge clock) disable iff (!rst_b)
        s_busy_end ##0 !short_run_r
        |-> run_len_r == 4'(sac_pkg::RES_BITS))
        else $error("Full conversion length wrong.");

    a_short_count: assert property (@(posedge clock) disable iff (!rst_b)
        s_busy_end ##0 short_run_r
        |-> run_len_r == 4'(sac_pkg::SHORT_BITS))
        else $error("Short conversion count wrong.");

    a_short_tail: assert property (@(posedge clock) disable iff (!rst_b)
        s_busy_end ##0 short_run_r
        |-> result[3:0] == 4'h0)
        else $error("Short result has low bits set.");

    a_sar_cleared: assert property (@(posedge clock) disable iff (!rst_b)
        start_taken
        |=> dac_code == 12'h800)
        else $error("Register not cleared at start.");

    a_upper_byte: assert property (@(posedge clock) disable iff (!rst_b)
        (reading && !word_format && !byte_address_bit)
        |-> result_data_oe == 12'hff0)
        else $error("Upper byte enable wrong.");

    a_read_decode: assert property (@(posedge clock) disable iff (!rst_b)
        (selected && read_convert && !busy)
        |-> result_data_oe != 12'h000)
        else $error("Decoded read left lines floating.");

    a_word_data: assert property (@(posedge clock) disable iff (!rst_b)
        (clk_en && word_format)
        |=> result_data_lines == $past(result))
        else $error("Word data wrong.");

    a_high_byte_data: assert property (@(posedge clock) disable iff (!rst_b)
        (clk_en && !word_format && !byte_address_bit)
        |=> result_data_lines == $past(result))
        else $error("Upper byte data wrong.");

    a_low_nibble: assert property (@(posedge clock) disable iff (!rst_b)
        (clk_en && !word_format && byte_address_bit)
        |=> result_data_lines[3:0] == 4'h0)
        else $error("Trailing zeros missing.");

    a_low_byte_data: assert property (@(posedge clock) disable iff (!rst_b)
        (clk_en && !word_format && byte_address_bit)
        |=> result_data_lines[7:4] == $past(result[3:0]))
        else $error("Low byte data wrong.");

    a_start_busy_kept: assert property (@(posedge clock) disable iff (!rst_b)
        (busy && start && run_len_r < 4'h7)
        |=> busy)
        else $error("Start during conversion disturbed it.");
endmodule : sac_control
`default_nettype wire

// [tb/sac_comp_model.sv]
/* Comparator model facing the converter trial code.
   Assumes a steady input that the bench sets as a code. */
`default_nettype none
module sac_comp_model (
    // Trial side.
    input wire logic [11:0] dac_code,
    input wire logic [11:0] level,
    output logic comp_below
);
    timeunit 1ns;
    timeprecision 1ns;
    // Below for kept bits.
    // The input sits half a step above level, so no code ties with it.
    assign comp_below = (dac_code <= level);
endmodule : sac_comp_model
`default_nettype wire

// [tb/sac_control_bench.sv]
/* Bench of the converter control block with its comparator model.
   Assumes the package and the control block are compiled first. */
`default_nettype none
module sac_control_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic cs_b = 1'b0;
    logic rc = 1'b1;
    logic ba = 1'b0;
    logic wf = 1'b1;
    logic below;
    logic [11:0] level = 12'ha5c;
    logic [11:0] dac, dl, oe;
    logic busy, cken;
    int err_count = 0;
    int checks_done = 0;
    sac_control i_dut (.clock(clock), .rst_b(rst_b), .clk_en(1'b1), .chip_enable(ce),
        .chip_select_b(cs_b), .read_convert(rc), .byte_address_bit(ba), .word_format(wf),
        .comp_below(below), .dac_code(dac), .conv_clock_en(cken),
        .conversion_busy_flag(busy), .result_data_lines(dl), .result_data_oe(oe));
    sac_comp_model i_comp (.dac_code(dac), .level(level), .comp_below(below));
    initial forever #25 clock = ~clock;
    task chk(input logic [11:0] got, input logic [11:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task conv(input logic b, input logic poke, input int n);
        int cnt;
        int w;
        cnt = 0;
        w = 0;
        @(posedge clock);
        ba <= b;
        rc <= 1'b1;
        @(posedge clock);
        rc <= 1'b0;
        while (busy !== 1'b1 && w < 4) begin
            @(negedge clock);
            w++;
        end
        while (busy === 1'b1 && cnt < 40) begin
            chk({11'h000, cken}, 12'h001);
            chk(oe, 12'h000);
            @(posedge clock);
            if (poke) rc <= (cnt == 4);
            @(negedge clock);
            cnt++;
        end
        chk(12'(cnt), 12'(n));
        repeat (2) @(negedge clock);
        chk({11'h000, busy}, 12'h000);
        $display("conversion test done");
    endtask : conv
    task rd(input logic f, input logic b, input logic [11:0] m, input logic [11:0] d);
        @(posedge clock);
        rc <= 1'b1;
        wf <= f;
        ba <= b;
        @(negedge clock);
        chk(oe, m);
        @(negedge clock);
        chk(dl & m, d);
        $display("read test done");
    endtask : rd
    task t_idle;
        for (int i = 0; i < 2; i++) begin
            @(posedge clock);
            ce <= i[0];
            cs_b <= i[0];
            @(negedge clock);
            chk(oe, 12'h000);
            @(posedge clock);
            rc <= 1'b0;
            repeat (4) @(negedge clock);
            chk({11'h000, busy}, 12'h000);
            @(posedge clock);
            ce <= 1'b1;
            cs_b <= 1'b0;
            rc <= 1'b1;
        end
        $display("idle test done");
    endtask : t_idle
    task final_report;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        conv(1'b0, 1'b0, 12);
        rd(1'b1, 1'b1, 12'hfff, 12'ha5c);
        rd(1'b0, 1'b0, 12'hff0, 12'ha50);
        rd(1'b0, 1'b1, 12'h0ff, 12'h0c0);
        conv(1'b1, 1'b0, 8);
        rd(1'b1, 1'b0, 12'hfff, 12'ha50);
        @(posedge clock);
        level <= 12'h3f1;
        conv(1'b0, 1'b0, 12);
        conv(1'b0, 1'b1, 12);
        rd(1'b1, 1'b0, 12'hfff, 12'h3f1);
        t_idle;
        final_report;
    end
    initial begin
        #20000;
        err_count++;
        final_report;
    end
endmodule : sac_control_bench
`default_nettype wire
